// *** rtl/sc_wait_pkg.sv ***
// =============================================================
// Shared constants of the smart card wait timers.
package sc_wait_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  // =============================================================
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_BLOCK_WAIT_BYTE3 = 16'hfe18;
  localparam logic [15:0] IDX_BLOCK_WAIT_BYTE2 = 16'hfe19;
  localparam logic [15:0] IDX_BLOCK_WAIT_BYTE1 = 16'hfe1a;
  localparam logic [15:0] IDX_BLOCK_WAIT_BYTE0 = 16'hfe1b;
  localparam logic [15:0] IDX_CHAR_WAIT_HIGH = 16'hfe1c;
  localparam logic [15:0] IDX_CHAR_WAIT_LOW = 16'hfe1d;
  localparam logic [15:0] IDX_ANSWER_TIMEOUT_HIGH = 16'hfe1f;
  localparam logic [15:0] IDX_ANSWER_TIMEOUT_LOW = 16'hfe20;
  localparam logic [15:0] IDX_FIRST_CHAR_TIMEOUT = 16'hfe21;
  localparam logic [15:0] IDX_RESET_RELEASE_LENGTH = 16'hfe22;
  localparam logic [15:0] IDX_CONTROL = 16'hfe30;
  localparam logic [15:0] IDX_STATUS = 16'hfe31;
  localparam logic [15:0] IDX_INT_STATUS = 16'hfe32;
  localparam logic [15:0] IDX_INT_ENABLE = 16'hfe33;
  localparam logic [15:0] IDX_INT_CLEAR = 16'hfe34;

  // =============================================================
  // Reset values.
  localparam logic [27:0] RST_BLOCK_WAIT = 28'h0000000;
  localparam logic [15:0] RST_CHAR_WAIT = 16'h0000;
  localparam logic [15:0] RST_ANSWER_TIMEOUT = 16'h0000;
  localparam logic [7:0] RST_FIRST_CHAR_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_RESET_RELEASE_LENGTH = 8'h70;
  localparam logic [3:0] RST_CONTROL = 4'h0;
  localparam logic [2:0] RST_INT = 3'h0;

  // =============================================================
  // Control bit positions.
  localparam int CTRL_T1_MODE = 0;
  localparam int CTRL_ANSWER_RECEIVE = 1;
  localparam int CTRL_FIRST_CHAR_DETECT = 2;
  localparam int CTRL_CARD_RESET_HOLD = 3;

  // =============================================================
  // Interrupt event bit positions.
  localparam int EV_WAIT = 0;
  localparam int EV_CHAR = 1;
  localparam int EV_ANSWER = 2;
  localparam int NUM_EVENTS = 3;

  // Card reset release sequence.
  typedef enum logic [1:0] {RST_HELD, RST_DELAY, RST_RELEASED} card_reset_state_t;

  // Turns a register index into its byte address.
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction
endpackage

// *** rtl/sc_wait_timers.sv ***
// Behaviour
// - Block wait limit is 28 bits over four byte registers, top nibble low.
// - T=1: time last sent character start to first received start bit.
// - T=0: same limit times gaps between consecutive characters either direction.
// - Block or work wait overrun raises the wait timeout interrupt.
// - 16-bit character wait times received start to next start, interrupts on overrun.
// - Answer duration exceeding its 16-bit limit flags answer timeout.
// - Answer timer armed by receive enable, starts at first start bit.
// - First character timer starts at reset release; missing character raises timeout.
// - Card reset release is delayed by the programmed length in ETUs.
// - Zero length and no hold releases reset once supply is good.
// - Hold bit pulls reset low at once; clearing releases after delay.
// - Hold set before power keeps reset until delay after clearing.
`timescale 1ns/10ps
module sc_wait_timers (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [sc_wait_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [sc_wait_pkg::DATA_W-1:0] PWDATA_IN,
  output logic [sc_wait_pkg::DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic ETU_CLK_IN,
  input wire logic CARD_SUPPLY_GOOD_IN,
  input wire logic TX_CHAR_START_IN,
  input wire logic RX_CHAR_START_IN,
  output logic CARD_RST_N_OUT,
  output logic IRQ_OUT
);
  import sc_wait_pkg::*;

  logic [27:0] block_wait_limit;
  logic [15:0] char_wait_limit;
  logic [15:0] answer_duration_limit;
  logic [7:0] first_char_limit;
  logic [7:0] reset_release_length;
  logic [3:0] control;
  logic [NUM_EVENTS-1:0] int_status;
  logic [NUM_EVENTS-1:0] int_enable;
  logic etu_sync1, etu_sync2, etu_prev;
  logic supply_sync1, card_supply_good;
  logic bw_run, cw_run, at_run, at_started, ts_run;
  logic [27:0] bw_count;
  logic [15:0] cw_count, at_count;
  logic [7:0] ts_count, rl_count;
  card_reset_state_t rst_state, next_rst_state;

  // =============================================================
  // APB decode
  // The slave answers two cycles after the setup cycle, so every access takes three cycles.
  wire access = PSEL_IN & PENABLE_IN;
  wire commit = access & PREADY_OUT;
  wire wr_commit = commit & PWRITE_IN;
  wire hit_bw3 = PADDR_IN == byte_addr(IDX_BLOCK_WAIT_BYTE3);
  wire hit_bw2 = PADDR_IN == byte_addr(IDX_BLOCK_WAIT_BYTE2);
  wire hit_bw1 = PADDR_IN == byte_addr(IDX_BLOCK_WAIT_BYTE1);
  wire hit_bw0 = PADDR_IN == byte_addr(IDX_BLOCK_WAIT_BYTE0);
  wire hit_cwh = PADDR_IN == byte_addr(IDX_CHAR_WAIT_HIGH);
  wire hit_cwl = PADDR_IN == byte_addr(IDX_CHAR_WAIT_LOW);
  wire hit_ath = PADDR_IN == byte_addr(IDX_ANSWER_TIMEOUT_HIGH);
  wire hit_atl = PADDR_IN == byte_addr(IDX_ANSWER_TIMEOUT_LOW);
  wire hit_fct = PADDR_IN == byte_addr(IDX_FIRST_CHAR_TIMEOUT);
  wire hit_rrl = PADDR_IN == byte_addr(IDX_RESET_RELEASE_LENGTH);
  wire hit_ctl = PADDR_IN == byte_addr(IDX_CONTROL);
  wire hit_sts = PADDR_IN == byte_addr(IDX_STATUS);
  wire hit_ist = PADDR_IN == byte_addr(IDX_INT_STATUS);
  wire hit_ien = PADDR_IN == byte_addr(IDX_INT_ENABLE);
  wire hit_icl = PADDR_IN == byte_addr(IDX_INT_CLEAR);
  wire mapped = hit_bw3 | hit_bw2 | hit_bw1 | hit_bw0 | hit_cwh | hit_cwl | hit_ath |
                hit_atl | hit_fct | hit_rrl | hit_ctl | hit_sts | hit_ist | hit_ien | hit_icl;
  wire [7:0] status_view = {3'b000, CARD_RST_N_OUT, ts_run, at_run, cw_run, bw_run};
  // The clear register is write-only and reads as zero.
  wire [7:0] read_byte =
    hit_bw3 ? {4'h0, block_wait_limit[27:24]} :
    hit_bw2 ? block_wait_limit[23:16] :
    hit_bw1 ? block_wait_limit[15:8] :
    hit_bw0 ? block_wait_limit[7:0] :
    hit_cwh ? char_wait_limit[15:8] :
    hit_cwl ? char_wait_limit[7:0] :
    hit_ath ? answer_duration_limit[15:8] :
    hit_atl ? answer_duration_limit[7:0] :
    hit_fct ? first_char_limit :
    hit_rrl ? reset_release_length :
    hit_ctl ? {4'h0, control} :
    hit_sts ? status_view :
    hit_ist ? {5'h00, int_status} :
    hit_ien ? {5'h00, int_enable} : 8'h00;
  wire [NUM_EVENTS-1:0] clear_mask = (wr_commit & hit_icl) ? PWDATA_IN[NUM_EVENTS-1:0] : '0;

  // Bus answer: ready for one cycle, data and error registered alongside it.
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= access & ~PREADY_OUT;
      PRDATA_OUT <= (access & ~PREADY_OUT & ~PWRITE_IN) ? {24'h000000, read_byte} : '0;
      PSLVERR_OUT <= access & ~PREADY_OUT & ~mapped;
    end
  end

  // =============================================================
  // Software-written limits and control
  // block wait packing
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      block_wait_limit <= RST_BLOCK_WAIT;
      char_wait_limit <= RST_CHAR_WAIT;
      answer_duration_limit <= RST_ANSWER_TIMEOUT;
      first_char_limit <= RST_FIRST_CHAR_TIMEOUT;
      reset_release_length <= RST_RESET_RELEASE_LENGTH;
      control <= RST_CONTROL;
      int_enable <= RST_INT;
    end else if (wr_commit) begin
      if (hit_bw3) block_wait_limit[27:24] <= PWDATA_IN[3:0];
      if (hit_bw2) block_wait_limit[23:16] <= PWDATA_IN[7:0];
      if (hit_bw1) block_wait_limit[15:8] <= PWDATA_IN[7:0];
      if (hit_bw0) block_wait_limit[7:0] <= PWDATA_IN[7:0];
      if (hit_cwh) char_wait_limit[15:8] <= PWDATA_IN[7:0];
      if (hit_cwl) char_wait_limit[7:0] <= PWDATA_IN[7:0];
      if (hit_ath) answer_duration_limit[15:8] <= PWDATA_IN[7:0];
      if (hit_atl) answer_duration_limit[7:0] <= PWDATA_IN[7:0];
      if (hit_fct) first_char_limit <= PWDATA_IN[7:0];
      if (hit_rrl) reset_release_length <= PWDATA_IN[7:0];
      if (hit_ctl) control <= PWDATA_IN[3:0];
      if (hit_ien) int_enable <= PWDATA_IN[NUM_EVENTS-1:0];
    end
  end

  wire t1_mode = control[CTRL_T1_MODE];
  wire answer_receive_enable = control[CTRL_ANSWER_RECEIVE];
  wire first_char_detect_enable = control[CTRL_FIRST_CHAR_DETECT];
  wire card_reset_hold = control[CTRL_CARD_RESET_HOLD];

  // =============================================================
  // Pin synchronisers and ETU tick
  // The ETU clock is slow against the system clock, so its rising edge is found by sampling.
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      etu_sync1 <= 1'b0;
      etu_sync2 <= 1'b0;
      etu_prev <= 1'b0;
      supply_sync1 <= 1'b0;
      card_supply_good <= 1'b0;
    end else begin
      etu_sync1 <= ETU_CLK_IN;
      etu_sync2 <= etu_sync1;
      etu_prev <= etu_sync2;
      supply_sync1 <= CARD_SUPPLY_GOOD_IN;
      card_supply_good <= supply_sync1;
    end
  end
  wire etu_tick = etu_sync2 & ~etu_prev;

  // =============================================================
  // Block or work wait timer
  // T1 start and stop
  wire bw_restart = TX_CHAR_START_IN | (~t1_mode & RX_CHAR_START_IN);
  wire bw_stop = t1_mode & RX_CHAR_START_IN;
  wire bw_timeout = bw_run & etu_tick & (bw_count >= block_wait_limit) & ~bw_restart & ~bw_stop;

  // Restart outranks stop so a character sent in the same cycle still starts a new wait.
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bw_run <= 1'b0;
      bw_count <= '0;
    end else if (bw_restart) begin
      bw_run <= 1'b1;
      bw_count <= '0;
    end else if (bw_stop | bw_timeout) begin
      bw_run <= 1'b0;
    end else if (bw_run & etu_tick) begin
      bw_count <= bw_count + 28'h0000001;
    end
  end

  // =============================================================
  // Character or initial wait timer
  // Our own transmission ends a receive wait, since the card is not expected to talk then.
  // character gap
  wire cw_timeout = cw_run & etu_tick & (cw_count >= char_wait_limit) & ~RX_CHAR_START_IN;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cw_run <= 1'b0;
      cw_count <= '0;
    end else if (RX_CHAR_START_IN) begin
      cw_run <= 1'b1;
      cw_count <= '0;
    end else if (TX_CHAR_START_IN | cw_timeout) begin
      cw_run <= 1'b0;
    end else if (cw_run & etu_tick) begin
      cw_count <= cw_count + 16'h0001;
    end
  end

  // =============================================================
  // Answer duration timer
  // answer overrun
  wire at_timeout = at_run & etu_tick & (at_count >= answer_duration_limit);
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      at_run <= 1'b0;
      at_started <= 1'b0;
      at_count <= '0;
    end else if (~answer_receive_enable) begin
      at_run <= 1'b0;
      at_started <= 1'b0;
    end else if (RX_CHAR_START_IN & ~at_started) begin
      at_run <= 1'b1;
      at_started <= 1'b1;
      at_count <= '0;
    end else if (at_timeout) begin
      at_run <= 1'b0;
    end else if (at_run & etu_tick) begin
      at_count <= at_count + 16'h0001;
    end
  end

  // =============================================================
  // First character timer
  wire ts_start = first_char_detect_enable & (rst_state != RST_RELEASED) &
                  (next_rst_state == RST_RELEASED);
  wire ts_timeout = ts_run & etu_tick & (ts_count >= first_char_limit) & ~RX_CHAR_START_IN;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ts_run <= 1'b0;
      ts_count <= '0;
    end else if (ts_start) begin
      ts_run <= 1'b1;
      ts_count <= '0;
    end else if (RX_CHAR_START_IN | ts_timeout | ~first_char_detect_enable) begin
      ts_run <= 1'b0;
    end else if (ts_run & etu_tick) begin
      ts_count <= ts_count + 8'h01;
    end
  end

  // =============================================================
  // Card reset release
  // A missing supply holds reset as firmly as the hold bit, so power-up obeys the same delay.
  wire reset_blocked = card_reset_hold | ~card_supply_good;
  wire [8:0] rl_next = {1'b0, rl_count} + 9'h001;
  wire delay_done = etu_tick & (rl_next >= {1'b0, reset_release_length});

  always_comb begin
    next_rst_state = rst_state;
    unique case (rst_state)
      RST_HELD: begin
        if (~reset_blocked) begin
          next_rst_state = (reset_release_length == 8'h00) ? RST_RELEASED : RST_DELAY;
        end
      end
      RST_DELAY: begin
        if (reset_blocked) begin
          next_rst_state = RST_HELD;
        end else if (delay_done) begin
          next_rst_state = RST_RELEASED;
        end
      end
      RST_RELEASED: begin
        if (reset_blocked) begin
          next_rst_state = RST_HELD;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rst_state <= RST_HELD;
      rl_count <= '0;
      CARD_RST_N_OUT <= 1'b0;
    end else begin
      rst_state <= next_rst_state;
      CARD_RST_N_OUT <= next_rst_state == RST_RELEASED;
      if (rst_state != RST_DELAY) begin
        rl_count <= '0;
      end else if (etu_tick) begin
        rl_count <= rl_next[7:0];
      end
    end
  end

  // =============================================================
  // Interrupts
  // A timeout in the cycle of its clear survives, because set is applied after clear.
  wire [NUM_EVENTS-1:0] events = {at_timeout | ts_timeout, cw_timeout, bw_timeout};
  wire [NUM_EVENTS-1:0] next_int_status = (int_status & ~clear_mask) | events;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      int_status <= RST_INT;
      IRQ_OUT <= 1'b0;
    end else begin
      int_status <= next_int_status;
      IRQ_OUT <= |(next_int_status & int_enable);
    end
  end

  // =============================================================
  // Assertions
  block_wait_top_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    wr_commit && hit_bw3 |=> block_wait_limit[27:24] == $past(PWDATA_IN[3:0]))
    else $error("Top nibble of block wait limit not loaded.");
  t1_wait_stop_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    t1_mode && RX_CHAR_START_IN && !TX_CHAR_START_IN |=> !bw_run)
    else $error("Block wait did not stop on received character.");
  t0_wait_restart_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !t1_mode && RX_CHAR_START_IN |=> bw_run && bw_count == 28'h0000000)
    else $error("Work wait did not restart on a character.");
  wait_timeout_irq_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    bw_timeout |=> int_status[EV_WAIT] && !bw_run)
    else $error("Wait timeout not flagged.");
  char_wait_restart_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    RX_CHAR_START_IN |=> cw_run && cw_count == 16'h0000)
    else $error("Character wait did not restart.");
  answer_timeout_irq_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    at_timeout |=> int_status[EV_ANSWER] && !at_run)
    else $error("Answer timeout not flagged.");
  answer_disable_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !answer_receive_enable |=> !at_run && !at_started)
    else $error("Answer timer runs while disabled.");
  first_char_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    ts_start |=> ts_run && ts_count == 8'h00 && CARD_RST_N_OUT)
    else $error("First character timer not started at reset release.");
  delay_release_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    rst_state == RST_DELAY && !reset_blocked && !delay_done |=> !CARD_RST_N_OUT)
    else $error("Card reset released before delay ran out.");
  zero_delay_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    rst_state == RST_HELD && !reset_blocked && reset_release_length == 8'h00
    |=> CARD_RST_N_OUT)
    else $error("Zero-length reset not released at once.");
  hold_low_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    card_reset_hold |=> !CARD_RST_N_OUT)
    else $error("Card reset high while hold is set.");
  tick_only_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !etu_tick && !bw_restart |=> bw_count == $past(bw_count))
    else $error("Block wait counter moved without a tick.");
endmodule

// *** testbench/card_model.sv ***
`timescale 1ns/10ps
// =============================================================
// Card side: a free running ETU clock and bursts of received characters.
module card_model (
  input wire logic clk,
  input wire logic card_rst_n,
  input wire logic tx_start,
  input wire logic [7:0] gap,
  input wire logic [7:0] count,
  output logic etu_clk,
  output logic rx_start
);
  logic rst_q = 1'b0;
  logic etu_q = 1'b0;
  logic [7:0] left = 8'h00;
  logic [7:0] wait_n = 8'h00;

  // The ETU clock comes from the card clock divider, which never stops.
  initial begin
    etu_clk = 1'b0;
    forever #400 etu_clk = ~etu_clk;
  end

  // A burst starts at reset release or after each sent character.
  // A count of zero makes the card mute, which is what timeouts need.
  always_ff @(posedge clk) begin
    rst_q <= card_rst_n;
    etu_q <= etu_clk;
    rx_start <= 1'b0;
    if ((card_rst_n && !rst_q) || tx_start) begin
      left <= count;
      wait_n <= gap;
    end else if (left != 8'h00 && etu_clk && !etu_q) begin
      if (wait_n <= 8'h01) begin
        rx_start <= 1'b1;
        left <= left - 8'h01;
        wait_n <= gap;
      end else begin
        wait_n <= wait_n - 8'h01;
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import sc_wait_pkg::*;
  localparam logic [31:0] T1 = 32'h1 << CTRL_T1_MODE;
  localparam logic [31:0] ANS = 32'h1 << CTRL_ANSWER_RECEIVE;
  localparam logic [31:0] DET = 32'h1 << CTRL_FIRST_CHAR_DETECT;
  localparam logic [31:0] HOLD = 32'h1 << CTRL_CARD_RESET_HOLD;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic etu_clk;
  logic supply_good = 1'b0;
  logic tx_start = 1'b0;
  logic rx_start;
  logic card_rst_n;
  logic irq;
  logic [7:0] gap = 8'h02;
  logic [7:0] count = 8'h00;
  logic [31:0] rdata;
  logic rerr;
  logic [15:0] idx;
  logic bad;
  int mismatches = 0;
  int tests_run = 0;

  // =============================================================
  // Clock, design and card.
  initial begin
    forever #50 clk = ~clk;
  end

  sc_wait_timers u_dut (
    .CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ETU_CLK_IN(etu_clk),
    .CARD_SUPPLY_GOOD_IN(supply_good), .TX_CHAR_START_IN(tx_start),
    .RX_CHAR_START_IN(rx_start), .CARD_RST_N_OUT(card_rst_n), .IRQ_OUT(irq)
  );

  card_model u_card (
    .clk(clk), .card_rst_n(card_rst_n), .tx_start(tx_start), .gap(gap),
    .count(count), .etu_clk(etu_clk), .rx_start(rx_start)
  );

  // =============================================================
  // Bus and check tasks.
  // Each transfer opens one edge after the last closed, so no signal
  // is driven twice in one time step.
  task automatic apb(input logic wr, input logic [15:0] i, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= byte_addr(i);
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rd(input logic [15:0] i);
    apb(1'b0, i, 32'h0);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic etus(input int n);
    repeat (n * 8) @(posedge clk);
  endtask

  task automatic tx();
    @(posedge clk);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Generous bound: the sequence needs well under two thousand cycles.
  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // =============================================================
  // Test sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, write and read back, and the hole at 0xfe1e.
    for (int i = 0; i < 11; i++) begin
      idx = IDX_BLOCK_WAIT_BYTE3 + 16'(i);
      bad = (idx == 16'hfe1e);
      rd(idx);
      check(rdata, (idx == IDX_RESET_RELEASE_LENGTH) ? 32'h70 : 32'h0);
      check(32'(rerr), 32'(bad));
      wr(idx, 32'ha5);
      rd(idx);
      check(rdata, bad ? 32'h0 : (idx == IDX_BLOCK_WAIT_BYTE3) ? 32'h05 : 32'ha5);
    end
    $display("test registers done");
    // Card reset held across power-up, then released after the delay.
    check(32'(card_rst_n), 32'h0);
    wr(IDX_CONTROL, HOLD);
    wr(IDX_RESET_RELEASE_LENGTH, 32'h04);
    supply_good <= 1'b1;
    etus(10);
    check(32'(card_rst_n), 32'h0);
    wr(IDX_CONTROL, 32'h0);
    etus(2);
    check(32'(card_rst_n), 32'h0);
    etus(6);
    check(32'(card_rst_n), 32'h1);
    wr(IDX_CONTROL, HOLD);
    repeat (2) @(negedge clk);
    check(32'(card_rst_n), 32'h0);
    wr(IDX_RESET_RELEASE_LENGTH, 32'h0);
    supply_good <= 1'b0;
    wr(IDX_CONTROL, 32'h0);
    repeat (4) @(negedge clk);
    check(32'(card_rst_n), 32'h0);
    @(posedge clk);
    supply_good <= 1'b1;
    repeat (6) @(negedge clk);
    check(32'(card_rst_n), 32'h1);
    // Status shows the released card reset and no timer running.
    rd(IDX_STATUS);
    check(rdata, 32'h10);
    $display("test card_reset done");
    // Mute card after release with detection on.
    wr(IDX_INT_ENABLE, 32'h7);
    wr(IDX_FIRST_CHAR_TIMEOUT, 32'h3);
    wr(IDX_CONTROL, DET | HOLD);
    wr(IDX_CONTROL, DET);
    etus(2);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h0);
    etus(6);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h1 << EV_ANSWER);
    @(negedge clk);
    check(32'(irq), 32'h1);
    wr(IDX_INT_CLEAR, 32'h7);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    $display("test first_char done");
    // Block wait in T=1: an answer stops it, a mute card times out.
    wr(IDX_CONTROL, T1);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_BLOCK_WAIT_BYTE3 + 16'(i), 32'h0);
    end
    wr(IDX_BLOCK_WAIT_BYTE0, 32'h5);
    count <= 8'h01;
    tx();
    etus(10);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h0);
    count <= 8'h00;
    tx();
    etus(3);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h0);
    etus(6);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h1 << EV_WAIT);
    $display("test block_wait done");
    // Character wait: three close characters, then silence.
    wr(IDX_CHAR_WAIT_HIGH, 32'h0);
    wr(IDX_CHAR_WAIT_LOW, 32'h3);
    count <= 8'h03;
    tx();
    wr(IDX_INT_CLEAR, 32'h7);
    etus(6);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h0);
    etus(7);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h1 << EV_CHAR);
    $display("test char_wait done");
    // T=0 answer of eight characters: duration overrun, then work wait.
    wr(IDX_CHAR_WAIT_HIGH, 32'hff);
    wr(IDX_ANSWER_TIMEOUT_HIGH, 32'h0);
    wr(IDX_ANSWER_TIMEOUT_LOW, 32'h4);
    wr(IDX_CONTROL, ANS);
    wr(IDX_INT_CLEAR, 32'h7);
    count <= 8'h08;
    tx();
    etus(4);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h0);
    etus(8);
    rd(IDX_INT_STATUS);
    check(rdata, 32'h1 << EV_ANSWER);
    etus(14);
    rd(IDX_INT_STATUS);
    check(rdata, (32'h1 << EV_ANSWER) | (32'h1 << EV_WAIT));
    // Masking keeps the line low while the status bits stay set.
    wr(IDX_INT_ENABLE, 32'h0);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    wr(IDX_INT_ENABLE, 32'h1 << EV_WAIT);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h1);
    $display("test answer_and_mask done");
    end_sim();
  end
endmodule
